// ---- rtl/scr_seq_ctrl.sv ----
// sequencer control registers, command and result fifos, apb slave
// assumes an apb master on clk_sys, synchronous active high reset
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "scr_defs.svh"
module scr_seq_ctrl (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // status
    output logic             seqRunning,
    output logic             ignoredReqIrq,
    output logic             resultAboveThr
);
    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        scr_pkg::scr_state_e st;
        logic        runEn;
        logic        stopOnEmpty;
        logic        freeze;
        logic [7:0]  wrDiv;
        logic [31:0] fifoCfg;
        logic [31:0] syncOut;
        logic [31:0] cmdCount;
        logic [29:0] timeout;
        logic [7:0]  crc;
        logic [19:0] slpLock;
        logic [31:0] slpTrig;
        logic [3:0][31:0] info;
        logic [31:0] partCfg;
        logic [31:0] thres;
        logic [4:0]  cmdWr;
        logic [4:0]  cmdRd;
        logic [4:0]  resWr;
        logic [4:0]  resRd;
        logic [31:0] cmd;
        logic [29:0] waitCnt;
        logic [7:0]  divCnt;
        logic        seqActive;
        logic [1:0]  seqId;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        above;
    } scr_state_s;

    scr_state_s s_ff;
    scr_state_s nxt_s;
    scr_mem_if  cmdMem ();
    scr_mem_if  resMem ();
    logic        access;
    logic [4:0]  cmdFill;
    logic [4:0]  resFill;
    logic        seqInfoWr;
    logic [1:0]  seqInfoIdx;
    logic [31:0] seqInfoData;
    logic        hostInfoWr;
    logic [1:0]  hostInfoIdx;

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [31:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            if (r[7] ^ d[i]) begin
                r = {r[6:0], 1'b0} ^ `SCR_CRC_POLY;
            end else begin
                r = {r[6:0], 1'b0};
            end
        end
        return r;
    endfunction : crc8

    function automatic logic [1:0] infoIdx(input logic [15:0] a);
        logic [1:0] r;
        r = 2'h0;
        unique case (a)
            `SCR_INFO1_OFF: r = 2'h1;
            `SCR_INFO2_OFF: r = 2'h2;
            `SCR_INFO3_OFF: r = 2'h3;
            default:        r = 2'h0;
        endcase
        return r;
    endfunction : infoIdx

    scr_mem u_cmdMem (.clk_sys(clk_sys), .port(cmdMem.mem));
    scr_mem u_resMem (.clk_sys(clk_sys), .port(resMem.mem));

    assign cmdFill = s_ff.cmdWr - s_ff.cmdRd;
    assign resFill = s_ff.resWr - s_ff.resRd;
    assign access  = psel & penable & ~s_ff.pready;

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        nxt_s          = s_ff;
        nxt_s.pready   = 1'b0;
        nxt_s.pslverr  = 1'b0;
        nxt_s.irq      = 1'b0;
        seqInfoWr      = 1'b0;
        seqInfoIdx     = s_ff.cmd[25:24];
        seqInfoData    = {16'h0, s_ff.cmd[15:0]};
        hostInfoWr     = 1'b0;
        hostInfoIdx    = infoIdx(paddr);
        cmdMem.wrEn    = 1'b0;
        cmdMem.wrAddr  = s_ff.cmdWr[3:0];
        cmdMem.wrData  = pwdata;
        cmdMem.rdAddr  = s_ff.cmdRd[3:0];
        resMem.wrEn    = 1'b0;
        resMem.wrAddr  = s_ff.resWr[3:0];
        resMem.wrData  = {7'h0, s_ff.seqId, s_ff.cmd[22:0]};
        resMem.rdAddr  = s_ff.resRd[3:0];

        // host side: one wait state, so fifo read data has settled
        if (access) begin
            nxt_s.pready = 1'b1;
            nxt_s.prdata = 32'h0;
            if (pwrite) begin
                unique case (paddr)
                    `SCR_SEQUENCER_CONFIG_OFF: begin
                        nxt_s.runEn       = pwdata[`SCR_RUN_BIT];
                        nxt_s.stopOnEmpty = pwdata[`SCR_STOP_BIT];
                        nxt_s.freeze      = pwdata[`SCR_FRZ_BIT];
                        nxt_s.wrDiv = pwdata[`SCR_DIV_LSB +: 8];
                    end
                    `SCR_FIFOCFG_OFF: nxt_s.fifoCfg = pwdata;
                    `SCR_SYNC_OFF:    nxt_s.syncOut = pwdata;
                    `SCR_CNT_OFF:     nxt_s.cmdCount = pwdata;
                    `SCR_LOCK_OFF:    nxt_s.slpLock = pwdata[19:0];
                    `SCR_SLP_OFF: begin
                        // locked unless the key was written first
                        if (s_ff.slpLock == `SCR_SLP_KEY) begin
                            nxt_s.slpTrig = pwdata;
                        end
                    end
                    `SCR_INFO0_OFF, `SCR_INFO1_OFF,
                    `SCR_INFO2_OFF, `SCR_INFO3_OFF: begin
                        hostInfoWr = 1'b1;
                        nxt_s.info[hostInfoIdx] = pwdata;
                    end
                    `SCR_PART_OFF:    nxt_s.partCfg = pwdata;
                    `SCR_THR_OFF:     nxt_s.thres = pwdata;
                    `SCR_CMD_OFF: begin
                        // full or frozen: word dropped, queue intact
                        if (cmdFill != `SCR_DEPTH && !s_ff.freeze) begin
                            cmdMem.wrEn = 1'b1;
                            nxt_s.cmdWr = s_ff.cmdWr + 5'h1;
                        end
                    end
                    `SCR_TRIG_OFF: begin
                        if (pwdata[3:0] != 4'h0) begin
                            if (s_ff.seqActive) begin
                                nxt_s.irq = 1'b1;
                            end else begin
                                nxt_s.seqActive = 1'b1;
                                nxt_s.seqId = pwdata[0] ? 2'h0 :
                                              pwdata[1] ? 2'h1 :
                                              pwdata[2] ? 2'h2 : 2'h3;
                            end
                        end
                    end
                    `SCR_CRC_OFF, `SCR_TMO_OFF, `SCR_RES_OFF,
                    `SCR_WPTR_OFF, `SCR_STAT_OFF: ;
                    default: nxt_s.pslverr = 1'b1;
                endcase
            end else begin
                unique case (paddr)
                    `SCR_SEQUENCER_CONFIG_OFF: nxt_s.prdata =
                        {16'h0, s_ff.wrDiv, 3'h0, s_ff.freeze,
                         2'h0, s_ff.stopOnEmpty, s_ff.runEn};
                    `SCR_FIFOCFG_OFF: nxt_s.prdata = s_ff.fifoCfg;
                    `SCR_SYNC_OFF:    nxt_s.prdata = s_ff.syncOut;
                    `SCR_CRC_OFF:     nxt_s.prdata = {24'h0, s_ff.crc};
                    `SCR_CNT_OFF:     nxt_s.prdata = s_ff.cmdCount;
                    `SCR_TMO_OFF:     nxt_s.prdata = {2'h0, s_ff.timeout};
                    `SCR_RES_OFF: begin
                        // empty, disabled or frozen: reads zero, no pop
                        if (resFill != 5'h0 && !s_ff.freeze &&
                            s_ff.fifoCfg[`SCR_RESEN_BIT]) begin
                            nxt_s.prdata = resMem.rdData;
                            nxt_s.resRd = s_ff.resRd + 5'h1;
                        end
                    end
                    `SCR_LOCK_OFF: nxt_s.prdata = {12'h0, s_ff.slpLock};
                    `SCR_SLP_OFF:  nxt_s.prdata = s_ff.slpTrig;
                    `SCR_INFO0_OFF, `SCR_INFO1_OFF,
                    `SCR_INFO2_OFF, `SCR_INFO3_OFF:
                        nxt_s.prdata = s_ff.info[hostInfoIdx];
                    `SCR_WPTR_OFF: nxt_s.prdata = {27'h0, s_ff.cmdWr};
                    `SCR_PART_OFF: nxt_s.prdata = s_ff.partCfg;
                    `SCR_THR_OFF:  nxt_s.prdata = s_ff.thres;
                    `SCR_STAT_OFF: nxt_s.prdata =
                        {5'h0, 6'h0, resFill, 5'h0, 6'h0, cmdFill};
                    `SCR_TRIG_OFF, `SCR_CMD_OFF: ;
                    default: nxt_s.pslverr = 1'b1;
                endcase
            end
        end

        // sequencer side: frozen means nothing moves at all
        if (!s_ff.freeze) begin
            unique case (s_ff.st)
                scr_pkg::ST_IDLE: begin
                    if (s_ff.runEn) begin
                        nxt_s.st = scr_pkg::ST_FETCH;
                    end
                end
                scr_pkg::ST_FETCH: begin
                    if (!s_ff.runEn) begin
                        nxt_s.st = scr_pkg::ST_IDLE;
                    end else if (cmdFill != 5'h0) begin
                        nxt_s.st = scr_pkg::ST_LOAD;
                    end else if (s_ff.stopOnEmpty) begin
                        nxt_s.runEn = 1'b0;
                        nxt_s.st = scr_pkg::ST_IDLE;
                    end
                end
                scr_pkg::ST_LOAD: begin
                    nxt_s.cmd = cmdMem.rdData;
                    nxt_s.cmdRd = s_ff.cmdRd + 5'h1;
                    nxt_s.crc = crc8(s_ff.crc, cmdMem.rdData);
                    nxt_s.cmdCount = s_ff.cmdCount + 32'h1;
                    nxt_s.waitCnt = cmdMem.rdData[29:0];
                    nxt_s.divCnt = 8'h0;
                    nxt_s.st = scr_pkg::ST_EXEC;
                end
                scr_pkg::ST_EXEC: begin
                    unique case (s_ff.cmd[31:30])
                        2'b00: begin
                            // wait commands ignore the divider
                            if (s_ff.waitCnt == 30'h0) begin
                                nxt_s.st = scr_pkg::ST_FETCH;
                            end else begin
                                nxt_s.waitCnt = s_ff.waitCnt - 30'h1;
                                nxt_s.timeout = s_ff.timeout + 30'h1;
                            end
                        end
                        2'b01, 2'b10: begin
                            if (s_ff.divCnt != s_ff.wrDiv) begin
                                nxt_s.divCnt = s_ff.divCnt + 8'h1;
                            end else begin
                                nxt_s.st = scr_pkg::ST_FETCH;
                                if (!s_ff.cmd[31]) begin
                                    seqInfoWr = 1'b1;
                                    nxt_s.info[seqInfoIdx] =
                                        seqInfoData;
                                end else if (resFill != `SCR_DEPTH &&
                                    s_ff.fifoCfg[`SCR_RESEN_BIT]) begin
                                    resMem.wrEn = 1'b1;
                                    nxt_s.resWr = s_ff.resWr + 5'h1;
                                end
                            end
                        end
                        2'b11: begin
                            nxt_s.seqActive = 1'b0;
                            nxt_s.st = scr_pkg::ST_FETCH;
                        end
                    endcase
                end
            endcase
        end

        // disabled result fifo is held empty
        if (!nxt_s.fifoCfg[`SCR_RESEN_BIT]) begin
            nxt_s.resWr = 5'h0;
            nxt_s.resRd = 5'h0;
        end
        nxt_s.above = {27'h0, nxt_s.resWr - nxt_s.resRd} > nxt_s.thres;
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_ff             <= '0;
            s_ff.st          <= scr_pkg::ST_IDLE;
            s_ff.stopOnEmpty <= 1'(`SCR_SEQUENCER_CONFIG_RST >> `SCR_STOP_BIT);
            s_ff.fifoCfg     <= `SCR_FIFOCFG_RST;
            s_ff.partCfg     <= `SCR_PART_RST;
            s_ff.crc         <= `SCR_CRC_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata         = s_ff.prdata;
    assign pready         = s_ff.pready;
    assign pslverr        = s_ff.pslverr;
    assign seqRunning     = s_ff.seqActive;
    assign ignoredReqIrq  = s_ff.irq;
    assign resultAboveThr = s_ff.above;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    run_start_a: assert property (
        s_ff.st == scr_pkg::ST_IDLE && s_ff.runEn && !s_ff.freeze
        |=> s_ff.st == scr_pkg::ST_FETCH)
        else $error("enabled sequencer did not start fetching");

    stop_empty_a: assert property (
        s_ff.st == scr_pkg::ST_FETCH && s_ff.runEn && !s_ff.freeze &&
        cmdFill == 5'h0 && s_ff.stopOnEmpty
        |=> !s_ff.runEn && s_ff.st == scr_pkg::ST_IDLE)
        else $error("sequencer kept running on empty queue");

    retry_fetch_a: assert property (
        s_ff.st == scr_pkg::ST_FETCH && s_ff.runEn && !s_ff.freeze &&
        cmdFill == 5'h0 && !s_ff.stopOnEmpty &&
        !(access && pwrite && paddr == `SCR_SEQUENCER_CONFIG_OFF)
        |=> s_ff.st == scr_pkg::ST_FETCH && s_ff.runEn)
        else $error("sequencer gave up fetching");

    freeze_hold_a: assert property (
        s_ff.freeze |=> $stable(s_ff.st) && $stable(s_ff.cmdRd) &&
        $stable(s_ff.waitCnt) && $stable(s_ff.divCnt))
        else $error("state moved while frozen");

    cfg_reset_a: assert property (
        $past(reset) |-> !s_ff.runEn && s_ff.stopOnEmpty &&
        !s_ff.freeze && s_ff.wrDiv == 8'h0 && s_ff.crc == 8'h01)
        else $error("configuration reset value wrong");

    seq_wins_a: assert property (
        seqInfoWr && !s_ff.freeze && hostInfoWr &&
        hostInfoIdx == seqInfoIdx
        |=> s_ff.info[$past(seqInfoIdx)] == $past(seqInfoData))
        else $error("host write beat sequencer write");

    ignore_req_a: assert property (
        access && pwrite && paddr == `SCR_TRIG_OFF &&
        pwdata[3:0] != 4'h0 && s_ff.seqActive
        |=> ignoredReqIrq && $stable(s_ff.seqId) ##1 !ignoredReqIrq)
        else $error("ignored request not reported");

    div_pace_a: assert property (
        s_ff.st == scr_pkg::ST_EXEC && !s_ff.freeze &&
        s_ff.cmd[31:30] == 2'b01 && s_ff.divCnt != s_ff.wrDiv
        |=> s_ff.st == scr_pkg::ST_EXEC)
        else $error("write command not paced by divider");

    cmd_push_a: assert property (
        access && pwrite && paddr == `SCR_CMD_OFF && !s_ff.freeze &&
        cmdFill != `SCR_DEPTH && s_ff.st != scr_pkg::ST_LOAD
        |=> cmdFill == $past(cmdFill) + 5'h1)
        else $error("command write not queued");

    empty_read_a: assert property (
        access && !pwrite && paddr == `SCR_RES_OFF && resFill == 5'h0
        |=> pready && prdata == 32'h0 && $stable(s_ff.resRd))
        else $error("empty result read not zero");

    apb_answer_a: assert property (
        access && !pwrite && paddr == `SCR_STAT_OFF
        |=> pready && prdata[4:0] == $past(cmdFill) &&
        prdata[20:16] == $past(resFill))
        else $error("fifo counts misreported");
endmodule : scr_seq_ctrl

// ---- rtl/scr_defs.svh ----
// constants of the sequencer control block: offsets, fields, resets, counts
// assumes byte addresses on a 32-bit apb bus, one word per register
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH
// ****************************************************
// register offsets
// ****************************************************
`define SCR_TRIG_OFF    16'h0430
`define SCR_SEQUENCER_CONFIG_OFF  16'h2004
`define SCR_FIFOCFG_OFF 16'h2008
`define SCR_SYNC_OFF    16'h2054
`define SCR_CRC_OFF     16'h2060
`define SCR_CNT_OFF     16'h2064
`define SCR_TMO_OFF     16'h2068
`define SCR_RES_OFF     16'h206c
`define SCR_CMD_OFF     16'h2070
`define SCR_LOCK_OFF    16'h2118
`define SCR_SLP_OFF     16'h211c
`define SCR_INFO0_OFF   16'h21cc
`define SCR_INFO2_OFF   16'h21d0
`define SCR_WPTR_OFF    16'h21d4
`define SCR_PART_OFF    16'h21d8
`define SCR_THR_OFF     16'h21e0
`define SCR_INFO3_OFF   16'h21e4
`define SCR_INFO1_OFF   16'h21e8
`define SCR_STAT_OFF    16'h2200
// ****************************************************
// fields and reset values
// ****************************************************
`define SCR_RUN_BIT     0
`define SCR_STOP_BIT    1
`define SCR_FRZ_BIT     4
`define SCR_DIV_LSB     8
`define SCR_RESEN_BIT   11
`define SCR_SEQUENCER_CONFIG_RST  32'h0000_0002
`define SCR_FIFOCFG_RST 32'h0000_1010
`define SCR_PART_RST    32'h0000_0410
`define SCR_CRC_RST     8'h01
`define SCR_CRC_POLY    8'h07
`define SCR_SLP_KEY     20'ha47e5
`define SCR_AW          4
`define SCR_DEPTH       5'h10
`endif

// ---- rtl/scr_pkg.sv ----
// types shared by the sequencer control block
// assumes scr_defs.svh is included where the constants are needed
package scr_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_LOAD  = 4'b0100,
        ST_EXEC  = 4'b1000
    } scr_state_e;
    typedef logic [31:0] scr_word_t;
endpackage : scr_pkg

// ---- rtl/scr_mem_if.sv ----
// carrier between the control block and its fifo storage
// assumes one clock, data read back one cycle after the address
`timescale 1ns/100ps
interface scr_mem_if;
    logic             wrEn;
    logic [3:0]       wrAddr;
    logic [3:0]       rdAddr;
    scr_pkg::scr_word_t wrData;
    scr_pkg::scr_word_t rdData;
    modport user (output wrEn, wrAddr, wrData, rdAddr, input rdData);
    modport mem  (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface : scr_mem_if

// ---- rtl/scr_mem.sv ----
// sixteen-word storage for one fifo, registered read data
// assumes the owner keeps pointers and never writes when full
`timescale 1ns/100ps
module scr_mem (
    // clock
    input wire logic  clk_sys,
    // storage port
    scr_mem_if.mem    port
);
    scr_pkg::scr_word_t store [16];
    scr_pkg::scr_word_t rdData_ff;

    // no reset on the array: contents are valid only behind the pointers
    always_ff @(posedge clk_sys) begin
        if (port.wrEn) begin
            store[port.wrAddr] <= port.wrData;
        end
        rdData_ff <= store[port.rdAddr];
    end

    assign port.rdData = rdData_ff;
endmodule : scr_mem

// ---- verification/scr_host_model.sv ----
// host-side apb master model for the sequencer control block
// assumes one clock; every request launched just after a rising edge
`timescale 1ns/100ps
module scr_host_model (
    // clock
    input  wire logic        clk_sys,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [15:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 16'h0000;
        pwdata  = 32'h0000_0000;
    end
    // ****
    // one transfer, held until pready; bounded so a dead slave cannot hang
    // ****
    task automatic xfer(input logic wr, input logic [15:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err, output logic hung);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd      = prdata;
        err     = pslverr;
        hung    = (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : scr_host_model

// ---- verification/sequencer_control_regs_tb.sv ----
// self-checking bench for the sequencer control block
// assumes scr_host_model as apb master, result fifo fed by the sequencer
`timescale 1ns/100ps
`include "scr_defs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module sequencer_control_regs_tb;
    logic        clk_sys;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        seqRunning;
    logic        ignoredReqIrq;
    logic        resultAboveThr;
    logic [31:0] d;
    logic        e;
    int          err_count = 0;
    int          num_checks = 0;
    int          irqSeen = 0;
    scr_seq_ctrl uut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .seqRunning(seqRunning), .ignoredReqIrq(ignoredReqIrq),
        .resultAboveThr(resultAboveThr));
    scr_host_model host (.clk_sys(clk_sys), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (ignoredReqIrq === 1'b1) irqSeen++;
    task automatic end_of_test();
        if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [31:0] wd);
        logic h;
        host.xfer(w, a, wd, d, e, h);
        if (h) begin
            err_count++;
            end_of_test();
        end
    endtask : acc
    // ****
    // scenarios
    // ****
    task automatic checkResets();
        logic [15:0] a [9] = '{16'h2004, 16'h2060, 16'h2064, 16'h2068,
            16'h206c, 16'h21e0, 16'h2200, 16'h21cc, 16'h2008};
        logic [31:0] v [9] = '{32'h2, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0,
            32'h0, 32'h0, 32'h1010};
        for (int i = 0; i < 9; i++) begin
            acc(1'b0, a[i], 32'h0);
            `CHK(d, v[i])
        end
    endtask : checkResets
    task automatic checkRegAccess();
        logic [15:0] a [4] = '{16'h21cc, 16'h21e8, 16'h21d0, 16'h21e4};
        for (int i = 0; i < 4; i++) acc(1'b1, a[i], 32'h1000 + i);
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, a[i], 32'h0);
            `CHK(d, 32'h1000 + i)
        end
        acc(1'b1, 16'h21e0, 32'h3);
        acc(1'b0, 16'h21e0, 32'h0);
        `CHK(d, 32'h3)
        acc(1'b1, 16'h21e0, 32'h0);
        acc(1'b1, 16'h2064, 32'h5);
        acc(1'b0, 16'h2064, 32'h0);
        `CHK(d, 32'h5)
        acc(1'b1, 16'h2060, 32'hff);
        acc(1'b0, 16'h2060, 32'h0);
        `CHK(d, 32'h1)
        acc(1'b0, 16'h2000, 32'h0);
        `CHK(e, 1'b1)
    endtask : checkRegAccess
    task automatic checkFreeze();
        acc(1'b1, 16'h2004, 32'h12);
        acc(1'b1, 16'h2070, 32'hc000_0000);
        acc(1'b0, 16'h2200, 32'h0);
        `CHK(d, 32'h0)
        // no stop on empty: the sequencer keeps retrying with run set
        acc(1'b1, 16'h2004, 32'h1);
        acc(1'b0, 16'h2004, 32'h0);
        `CHK(d, 32'h1)
        acc(1'b1, 16'h2004, 32'h2);
        // host side loads the program word by word
        acc(1'b1, 16'h2070, 32'h0000_0028);
        acc(1'b1, 16'h2070, 32'h4100_1234);
        acc(1'b1, 16'h2070, 32'h8000_00ab);
        acc(1'b1, 16'h2070, 32'hc000_0000);
        acc(1'b0, 16'h2200, 32'h0);
        `CHK(d, 32'h4)
    endtask : checkFreeze
    task automatic checkRun();
        int n;
        logic [31:0] t;
        acc(1'b1, 16'h2008, 32'h1810);
        acc(1'b1, 16'h0430, 32'h1);
        `CHK(seqRunning, 1'b1)
        // divider of 2 stretches every write command to three cycles
        acc(1'b1, 16'h2004, 32'h0203);
        // second trigger lands inside the 40-cycle wait command
        acc(1'b1, 16'h0430, 32'h2);
        // freeze inside the wait: the timeout count must not move
        acc(1'b1, 16'h2004, 32'h0213);
        acc(1'b0, 16'h2068, 32'h0);
        t = d;
        acc(1'b0, 16'h2068, 32'h0);
        `CHK(d, t)
        acc(1'b1, 16'h2004, 32'h0203);
        n = 0;
        do begin
            acc(1'b0, 16'h2004, 32'h0);
            n++;
        end while (d[0] !== 1'b0 && n < 60);
        `CHK(d, 32'h0202)
        `CHK(seqRunning, 1'b0)
        `CHK(irqSeen, 1)
        `CHK(resultAboveThr, 1'b1)
        acc(1'b0, 16'h21e8, 32'h0);
        `CHK(d, 32'h1234)
        acc(1'b0, 16'h2064, 32'h0);
        `CHK(d, 32'h9)
        acc(1'b0, 16'h2068, 32'h0);
        `CHK(d, 32'h28)
        acc(1'b0, 16'h2200, 32'h0);
        `CHK(d, 32'h0001_0000)
        acc(1'b1, 16'h21e0, 32'h1);
        `CHK(resultAboveThr, 1'b0)
        acc(1'b0, 16'h206c, 32'h0);
        `CHK(d, 32'h0000_00ab)
        acc(1'b0, 16'h206c, 32'h0);
        `CHK(d, 32'h0)
    endtask : checkRun
    initial begin
        reset = 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        checkResets();
        checkRegAccess();
        checkFreeze();
        checkRun();
        end_of_test();
    end
endmodule : sequencer_control_regs_tb
